// [design/instrument_status_groups.sv]
`timescale 1ns/100ps
module instrument_status_groups
   import status_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rstn,
   // Instrument state, same clock domain
   input  wire logic                calibrating,
   input  wire logic                measuring,
   input  wire logic                waiting_trigger,
   input  wire logic                config_changed,
   input  wire logic                remote_locked,
   input  wire logic                volt_overload,
   input  wire logic                curr_overload,
   input  wire logic                out_over_voltage,
   input  wire logic                out_over_current,
   input  wire logic                freq_out_of_range,
   input  wire logic                cal_corrupt,
   input  wire logic                res_overload,
   input  wire logic                cap_out_of_range,
   input  wire logic                limit_test_active,
   input  wire logic                reading_below_lower,
   input  wire logic                reading_above_upper,
   // Host command port
   input  wire status_pkg::cmd_t    cmd,
   output status_pkg::rsp_t         rsp,
   output logic                     ques_summary
);
   import status_pkg::*;

   // ----------------------------------------------------------------
   // Condition vectors
   // ----------------------------------------------------------------
   logic [15:0] oper_cond;
   logic [15:0] ques_cond;

   always_comb begin
      oper_cond                = 16'h0000;
      oper_cond[OPER_CAL]      = calibrating;
      oper_cond[OPER_MEAS]     = measuring;
      oper_cond[OPER_WAIT_TRG] = waiting_trigger;
      oper_cond[OPER_CFG_CHG]  = config_changed;
      oper_cond[OPER_LOCKED]   = remote_locked;
   end

   always_comb begin
      ques_cond                = 16'h0000;
      ques_cond[QUES_VOLT_OVL] = volt_overload;
      ques_cond[QUES_CURR_OVL] = curr_overload;
      ques_cond[QUES_OUT_OV]   = out_over_voltage;
      ques_cond[QUES_OUT_OC]   = out_over_current;
      ques_cond[QUES_FREQ]     = freq_out_of_range;
      ques_cond[QUES_CAL_BAD]  = cal_corrupt;
      ques_cond[QUES_RES_OVL]  = res_overload;
      ques_cond[QUES_CAP]      = cap_out_of_range;
      // Limit flags only count while a limit test runs
      ques_cond[QUES_LIM_LO]   = limit_test_active & reading_below_lower;
      ques_cond[QUES_LIM_HI]   = limit_test_active & reading_above_upper;
   end

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   logic        rd_cmd;
   logic        oper_clr;
   logic        ques_clr;
   logic        oper_en_we;
   logic        ques_en_we;

   assign rd_cmd     = cmd.valid & ~cmd.write & ~cmd.clear_status;
   // Reading an event register is the query that empties it
   assign oper_clr   = cmd.valid & (cmd.clear_status |
                       (rd_cmd & (cmd.sel == SEL_OPER_EVENT)));
   assign ques_clr   = cmd.valid & (cmd.clear_status |
                       (rd_cmd & (cmd.sel == SEL_QUES_EVENT)));
   assign oper_en_we = cmd.valid & cmd.write & ~cmd.clear_status &
                       (cmd.sel == SEL_OPER_EN);
   assign ques_en_we = cmd.valid & cmd.write & ~cmd.clear_status &
                       (cmd.sel == SEL_QUES_EN);

   // ----------------------------------------------------------------
   // Groups
   // ----------------------------------------------------------------
   logic [15:0] oper_cond_q;
   logic [15:0] oper_event_q;
   logic [15:0] oper_en_q;
   logic [15:0] ques_cond_q;
   logic [15:0] ques_event_q;
   logic [15:0] ques_en_q;
   logic        ques_sum_q;

   status_group #(
      .USED_MASK    (OPER_USED_MASK)
   ) u_oper (
      .core_clk     (core_clk),
      .rstn         (rstn),
      .cond_in      (oper_cond),
      .event_clear  (oper_clr),
      .enable_we    (oper_en_we),
      .enable_wdata (cmd.wdata),
      .cond_q       (oper_cond_q),
      .event_q      (oper_event_q),
      .enable_q     (oper_en_q),
      // Operation summary has no bit in this status byte, so it is left open
      .summary_q    ()
   );

   status_group #(
      .USED_MASK    (QUES_USED_MASK)
   ) u_ques (
      .core_clk     (core_clk),
      .rstn         (rstn),
      .cond_in      (ques_cond),
      .event_clear  (ques_clr),
      .enable_we    (ques_en_we),
      .enable_wdata (cmd.wdata),
      .cond_q       (ques_cond_q),
      .event_q      (ques_event_q),
      .enable_q     (ques_en_q),
      .summary_q    (ques_sum_q)
   );

   // ----------------------------------------------------------------
   // Read answer, one cycle after the command
   // ----------------------------------------------------------------
   logic [15:0] rdata_d;
   logic [15:0] stb_view;

   always_comb begin
      stb_view               = 16'h0000;
      stb_view[STB_QUES_SUM] = ques_sum_q;
   end

   always_comb begin
      case (cmd.sel)
         SEL_OPER_COND:  rdata_d = oper_cond_q;
         SEL_OPER_EVENT: rdata_d = oper_event_q;
         SEL_OPER_EN:    rdata_d = oper_en_q;
         SEL_QUES_COND:  rdata_d = ques_cond_q;
         SEL_QUES_EVENT: rdata_d = ques_event_q;
         SEL_QUES_EN:    rdata_d = ques_en_q;
         SEL_STB:        rdata_d = stb_view;
         default:        rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rsp <= '0;
      end else begin
         rsp.valid <= rd_cmd;
         rsp.rdata <= rd_cmd ? rdata_d : 16'h0000;
      end
   end

   // Summary is already registered; re-register so the port is a flop
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ques_summary <= 1'b0;
      end else begin
         ques_summary <= ques_sum_q;
      end
   end

endmodule : instrument_status_groups

// [design/status_group.sv]
`timescale 1ns/100ps
// One condition/event/enable triple with its summary bit.
module status_group
   import status_pkg::*;
#(
   parameter logic [15:0] USED_MASK = 16'hFFFF
) (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [15:0] cond_in,
   input  wire logic        event_clear,
   input  wire logic        enable_we,
   input  wire logic [15:0] enable_wdata,
   output logic      [15:0] cond_q,
   output logic      [15:0] event_q,
   output logic      [15:0] enable_q,
   output logic             summary_q
);
   logic [15:0] cond_d;
   logic [15:0] event_d;

   assign cond_d = cond_in & USED_MASK;

   // Condition follows state every cycle; reads never touch it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cond_q <= 16'h0000;
      end else begin
         cond_q <= cond_d;
      end
   end

   // Rising edge of a condition latches; set beats a same-cycle clear
   assign event_d = (event_clear ? 16'h0000 : event_q) | (cond_d & ~cond_q);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         event_q <= EVENT_RESET;
      end else begin
         event_q <= event_d;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         enable_q <= ENABLE_RESET;
      end else if (enable_we) begin
         enable_q <= enable_wdata & USED_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         summary_q <= 1'b0;
      end else begin
         summary_q <= |(event_d & enable_q);
      end
   end

endmodule : status_group

// [shared/status_pkg.sv]
package status_pkg;

   // -------------------------------------------------------------
   // Register selection on the command port
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_OPER_COND  = 3'h0,
      SEL_OPER_EVENT = 3'h1,
      SEL_OPER_EN    = 3'h2,
      SEL_QUES_COND  = 3'h3,
      SEL_QUES_EVENT = 3'h4,
      SEL_QUES_EN    = 3'h5,
      SEL_STB        = 3'h6
   } reg_sel_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        clear_status;
      reg_sel_t    sel;
      logic [15:0] wdata;
   } cmd_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] rdata;
   } rsp_t;

   // -------------------------------------------------------------
   // Bit positions
   // -------------------------------------------------------------
   localparam int OPER_CAL      = 0;
   localparam int OPER_MEAS     = 4;
   localparam int OPER_WAIT_TRG = 5;
   localparam int OPER_CFG_CHG  = 8;
   localparam int OPER_LOCKED   = 10;

   localparam int QUES_VOLT_OVL = 0;
   localparam int QUES_CURR_OVL = 1;
   localparam int QUES_OUT_OV   = 2;
   localparam int QUES_OUT_OC   = 3;
   localparam int QUES_FREQ     = 5;
   localparam int QUES_CAL_BAD  = 8;
   localparam int QUES_RES_OVL  = 9;
   localparam int QUES_CAP      = 10;
   localparam int QUES_LIM_LO   = 11;
   localparam int QUES_LIM_HI   = 12;

   localparam int STB_QUES_SUM  = 3;

   localparam logic [15:0] OPER_USED_MASK = 16'h0531;
   localparam logic [15:0] QUES_USED_MASK = 16'h1F2F;

   localparam logic [15:0] EVENT_RESET  = 16'h0000;
   localparam logic [15:0] ENABLE_RESET = 16'h0000;

endpackage : status_pkg

// [test/instrument_status_groups_sva.sv]
`timescale 1ns/100ps
module instrument_status_groups_sva
   import status_pkg::*;
(
   input wire logic             core_clk,
   input wire logic             rstn,
   input wire logic             calibrating,
   input wire logic             remote_locked,
   input wire status_pkg::cmd_t cmd,
   input wire status_pkg::rsp_t rsp,
   input wire logic             ques_summary
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic rd;
   logic wq;
   assign rd = cmd.valid && !cmd.write && !cmd.clear_status;
   assign wq = cmd.valid && cmd.write && cmd.sel == SEL_QUES_EN;
   sequence read_of(reg_sel_t s);
      rd && cmd.sel == s;
   endsequence
   // Empty questionable mask written, then three quiet cycles
   sequence mask_cleared;
      wq && cmd.wdata == 16'h0000 ##1 (!wq)[*3];
   endsequence
   chk_read_answer: assert property (rd |=> rsp.valid)
      else $error("read not answered");
   chk_no_stray_rsp: assert property (!rd |=> !rsp.valid)
      else $error("answer without read");
   chk_oper_spare_zero: assert property (
      rd && cmd.sel <= 3'h2 |=> (rsp.rdata & ~OPER_USED_MASK) == 16'h0000)
      else $error("operation spare bit set");
   chk_ques_spare_zero: assert property (
      rd && cmd.sel inside {[3'h3:3'h5]} |=> (rsp.rdata & ~QUES_USED_MASK) == 16'h0000)
      else $error("questionable spare bit set");
   chk_stb_only_b3: assert property (
      read_of(SEL_STB) |=> (rsp.rdata & 16'hFFF7) == 16'h0000)
      else $error("status byte stray bit");
   chk_sel7_zero: assert property (rd && cmd.sel == 3'h7 |=> rsp.rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_cal_live: assert property (
      $stable(calibrating)[*3] ##0 read_of(SEL_OPER_COND)
      |=> rsp.rdata[0] == $past(calibrating, 2))
      else $error("calibration bit stale");
   chk_lock_live: assert property (
      $stable(remote_locked)[*3] ##0 read_of(SEL_OPER_COND)
      |=> rsp.rdata[10] == $past(remote_locked, 2))
      else $error("lock bit stale");
   chk_mask_blocks: assert property (mask_cleared |-> !ques_summary)
      else $error("summary with empty mask");
endmodule : instrument_status_groups_sva
bind instrument_status_groups instrument_status_groups_sva chk (.core_clk(core_clk), .rstn(rstn),
   .calibrating(calibrating), .remote_locked(remote_locked), .cmd(cmd), .rsp(rsp),
   .ques_summary(ques_summary));

// [test/instrument_status_groups_tb.sv]
`timescale 1ns/100ps
module instrument_status_groups_tb;
   import status_pkg::*;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [15:0] st = 16'h0000;
   logic [15:0] r;
   logic [15:0] v;
   cmd_t        cmd;
   rsp_t        rsp;
   logic        ques_summary;
   int          mismatches = 0;
   int          n_checks = 0;
   int          seed = 32'h1FFB4A41;
   always #5 core_clk = ~core_clk;
   instrument_status_groups uut (.core_clk(core_clk), .rstn(rstn), .calibrating(st[0]),
      .measuring(st[1]), .waiting_trigger(st[2]), .config_changed(st[3]), .remote_locked(st[4]),
      .volt_overload(st[5]), .curr_overload(st[6]), .out_over_voltage(st[7]),
      .out_over_current(st[8]), .freq_out_of_range(st[9]), .cal_corrupt(st[10]),
      .res_overload(st[11]), .cap_out_of_range(st[12]), .limit_test_active(st[13]),
      .reading_below_lower(st[14]), .reading_above_upper(st[15]), .cmd(cmd), .rsp(rsp),
      .ques_summary(ques_summary));
   status_host_model host (.core_clk(core_clk), .cmd(cmd), .rsp(rsp));
   // --------------------------------------------------------------
   // Expected register images from the stimulus vector
   // --------------------------------------------------------------
   function automatic logic [15:0] exp_oper(input logic [15:0] x);
      return {5'h00, x[4], 1'b0, x[3], 2'h0, x[2], x[1], 3'h0, x[0]};
   endfunction : exp_oper
   function automatic logic [15:0] exp_ques(input logic [15:0] x);
      return {3'h0, x[15] & x[13], x[14] & x[13], x[12:10], 2'h0, x[9], 1'b0, x[8:5]};
   endfunction : exp_ques
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input reg_sel_t s, input logic [15:0] exp);
      host.xfer(1'b0, 1'b0, s, 16'h0000, r);
      chk(r, exp);
   endtask : rd
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #500000;
      mismatches++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge core_clk);
      #1 rstn = 1'b1;
      rd(SEL_OPER_EN, 16'h0000);
      rd(SEL_QUES_EVENT, 16'h0000);
      host.xfer(1'b1, 1'b0, SEL_OPER_EN, 16'hFFFF, r);
      rd(SEL_OPER_EN, 16'h0531);
      host.xfer(1'b1, 1'b0, SEL_QUES_EN, 16'hFFFF, r);
      rd(SEL_QUES_EN, 16'h1F2F);
      host.xfer(1'b1, 1'b0, SEL_OPER_COND, 16'hFFFF, r);
      rd(SEL_OPER_COND, 16'h0000);
      rd(reg_sel_t'(3'h7), 16'h0000);
      // Two corners first: everything on, then the same without a limit test
      for (int i = 0; i < 40; i++) begin
         v = 16'($random(seed));
         if (i == 0) v = 16'hFFFF;
         if (i == 1) v = 16'hDFFF;
         st = v;
         rd(SEL_OPER_COND, exp_oper(v));
         rd(SEL_QUES_COND, exp_ques(v));
         rd(SEL_QUES_COND, exp_ques(v));
      end
      st = 16'h0000;
      host.xfer(1'b0, 1'b1, SEL_OPER_COND, 16'h0000, r);
      rd(SEL_OPER_EVENT, 16'h0000);
      host.xfer(1'b1, 1'b0, SEL_QUES_EN, 16'h0000, r);
      st = 16'h0020;
      @(posedge core_clk);
      #1 st = 16'h0000;
      rd(SEL_QUES_EVENT, 16'h0001);
      rd(SEL_QUES_EVENT, 16'h0000);
      st = 16'h0020;
      repeat (3) @(posedge core_clk);
      #1;
      chk({15'h0000, ques_summary}, 16'h0000);
      host.xfer(1'b1, 1'b0, SEL_QUES_EN, 16'h0001, r);
      repeat (2) @(posedge core_clk);
      #1;
      chk({15'h0000, ques_summary}, 16'h0001);
      rd(SEL_STB, 16'h0008);
      host.xfer(1'b0, 1'b1, SEL_OPER_COND, 16'h0000, r);
      repeat (2) @(posedge core_clk);
      #1;
      chk({15'h0000, ques_summary}, 16'h0000);
      rd(SEL_STB, 16'h0000);
      rd(SEL_QUES_EN, 16'h0001);
      // Operation events latch on a rising condition and empty on query
      st = 16'h0008;
      rd(SEL_OPER_EVENT, 16'h0100);
      rd(SEL_OPER_EVENT, 16'h0000);
      report_and_stop;
   end
endmodule : instrument_status_groups_tb

// [test/status_host_model.sv]
`timescale 1ns/100ps
module status_host_model
   import status_pkg::*;
(
   input  wire logic             core_clk,
   output status_pkg::cmd_t      cmd,
   input  wire status_pkg::rsp_t rsp
);
   initial cmd = '0;
   // --------------------------------------------------------------
   // One request per call, so every answer pairs with its request
   // --------------------------------------------------------------
   task automatic xfer(input logic w, input logic c, input reg_sel_t s,
                       input logic [15:0] d, output logic [15:0] r);
      @(posedge core_clk);
      #1;
      cmd = '{valid: 1'b1, write: w, clear_status: c, sel: s, wdata: d};
      @(posedge core_clk);
      #1;
      cmd.valid = 1'b0;
      cmd.wdata = ~d;
      r = (rsp.valid === 1'b1) ? rsp.rdata : 16'hXXXX;
   endtask : xfer
endmodule : status_host_model
